// [shared/bridge_pkg.sv]
/*
  Shared constants and types for the host bridge strap, arbitration,
  clock-run and configuration-cycle logic and for the board-side end.
  Assumes a 50 MHz system clock common to both ends of the link.
*/
`default_nettype none
package bridge_pkg;
  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_MASTERS = 5;
  localparam int NUM_BANKS = 6;
  localparam int STRAP_W = 6;
  localparam int IDSEL_W = 21;
  localparam int HOST_FREQ_MHZ = 66;
  localparam int IOQ_DEPTH_MAX = 8;
  localparam int IOQ_DEPTH_MIN = 1;
  localparam int MGMT_RAM_EXT_KB = 1024;
  localparam int SYS_CLK_MHZ = 50;
  localparam int PCI_CLK_NS = 160;
  localparam int PCI_HALF_CYC = PCI_CLK_NS * SYS_CLK_MHZ / 2000;
  localparam int RUN_IDLE_PCLKS = 4;
  // ----------------------------------------------------------------
  // strap line positions and their unstrapped levels
  // ----------------------------------------------------------------
  localparam int STRAP_HOST_FREQ = 0;
  localparam int STRAP_QUEUE = 1;
  localparam int STRAP_QSTART = 2;
  localparam int STRAP_GFX_DIS = 3;
  localparam int STRAP_MEMMAP = 4;
  localparam int STRAP_BUFMODE = 5;
  localparam logic [5:0] STRAP_DEFAULT = 6'h37;
  // ----------------------------------------------------------------
  // register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG_ADDR = 8'h08;
  localparam logic [7:0] REG_CFG_DATA = 8'h0C;
  localparam logic [7:0] REG_CFG_RDATA = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_SUSP_LSB = 0;
  localparam int CTRL_EXT_MGMT = 2;
  localparam int CTRL_CKE_LSB = 8;
  localparam int CFG_EN_BIT = 31;
  localparam int CFG_BUS_LSB = 16;
  localparam int CFG_DEV_LSB = 11;
  localparam int CFG_REG_LSB = 2;
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_OK = 6;
  localparam int ST_RUN = 7;
  localparam int ST_CORE = 8;
  localparam int ST_GNT_LSB = 9;
  localparam int ST_BUSY = 14;
  localparam int ST_MISS = 15;
  localparam int ST_FAST = 16;
  // ----------------------------------------------------------------
  // device numbers on the configuration bus
  // ----------------------------------------------------------------
  localparam logic [4:0] SELF_DEV = 5'h00;
  localparam logic [4:0] GFX_DEV = 5'h01;
  localparam logic [4:0] MAX_DEV = 5'h14;
  localparam logic [4:0] SOUTH_DEV = 5'h07;

  typedef enum logic [1:0] {
    SUSP_NONE = 2'b00,
    SUSP_MEM = 2'b01,
    SUSP_STORAGE = 2'b10,
    SUSP_POWERED = 2'b11
  } susp_t;

  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_REQ = 2'b01,
    CFG_DROP = 2'b10
  } cfg_st_t;
endpackage
`default_nettype wire

// [shared/bridge_link_if.sv]
/*
  Link between the bridge end and the board end: strap lines,
  request/grant pairs, clock-run wire, bridge-made PCI clock and a
  four-phase configuration-cycle handshake.
  Assumes clkrun_n is pulled up on the board when nobody drives low.
*/
`default_nettype none
interface bridge_link_if;
  import bridge_pkg::*;
  logic [STRAP_W-1:0] strap;
  logic [NUM_MASTERS-1:0] req_n;
  logic [NUM_MASTERS-1:0] gnt_n;
  logic pci_clk;
  logic dev_crun_o;
  logic dev_crun_oe;
  logic brd_crun_o;
  logic brd_crun_oe;
  logic clkrun_n;
  logic cfg_req;
  logic cfg_ack;
  logic cfg_wr;
  logic [5:0] cfg_reg;
  logic [31:0] cfg_wd;
  logic [31:0] cfg_rd;
  logic [IDSEL_W-1:0] idsel;

  // open-drain wire with pull-up
  assign clkrun_n = !((dev_crun_oe && !dev_crun_o) || (brd_crun_oe && !brd_crun_o));

  modport dev_mp(input strap, req_n, clkrun_n, cfg_ack, cfg_rd,
                 output gnt_n, pci_clk, dev_crun_o, dev_crun_oe, cfg_req, cfg_wr, cfg_reg, cfg_wd, idsel);
  modport brd_mp(input gnt_n, pci_clk, clkrun_n, cfg_req, cfg_wr, cfg_reg, cfg_wd, idsel,
                 output strap, req_n, brd_crun_o, brd_crun_oe, cfg_ack, cfg_rd);
endinterface
`default_nettype wire

// [rtl/bus_arbiter.sv]
/*
  Round-robin arbiter; the owner keeps the grant while it asks, and no grant is held when nobody asks.
  Assumes req is already synchronous to clk_sys; grants move only on step.
*/
`default_nettype none
module bus_arbiter
  import bridge_pkg::*;
#(
  parameter int N = NUM_MASTERS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic step,
  input wire logic [N-1:0] req,
  output logic [N-1:0] gnt
);
  typedef struct packed {
    logic [N-1:0] gnt;
    logic [2:0] last;
  } arb_state_t;

  arb_state_t s_r;
  arb_state_t s_nxt;
  int idx;
  logic found;

  // owner keeps the bus while it asks; otherwise rotate past last owner
  always_comb begin
    s_nxt = s_r;
    idx = 0;
    found = 1'b0;
    if (step && (s_r.gnt & req) == '0) begin
      s_nxt.gnt = '0;
      for (int i = 1; i <= N; i++) begin
        idx = (int'(s_r.last) + i) % N;
        if (!found && req[idx]) begin
          found = 1'b1;
          s_nxt.gnt[idx] = 1'b1;
          s_nxt.last = 3'(idx);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign gnt = s_r.gnt;
endmodule
`default_nettype wire

// [rtl/bridge_dev.sv]
/*
  Host bridge end: strap capture, PCI clock generation under the
  clock-run protocol, bus arbitration, configuration cycles by
  mechanism one, internal clock gating and power-mode controls.
  Assumes link inputs come from another domain and are synchronised here, all but cfg_rd;
  software register port is single-cycle with read data one cycle later.
*/
`default_nettype none
module bridge_dev
  import bridge_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  bridge_link_if.dev_mp lnk,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic cpu_active,
  output logic core_clk_en,
  output susp_t susp_state,
  output logic mgmt_ram_ext,
  output logic [3:0] ioq_depth,
  output logic quick_start,
  output logic gfx_port_en,
  output logic std_mem_mode,
  output logic fsb_buffers,
  output logic [NUM_BANKS-1:0] bank_cke
);
  typedef struct packed {
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap;
    logic strap_ok;
    logic [1:0] cap;
    logic [NUM_MASTERS-1:0] req_s1;
    logic [NUM_MASTERS-1:0] req_s2;
    logic crun_s1;
    logic crun_s2;
    logic ack_s1;
    logic ack_s2;
    logic [31:0] ctrl;
    logic [31:0] cfg_addr;
    logic [31:0] cfg_rdata;
    logic [31:0] rdata;
    logic [2:0] div;
    logic pclk;
    logic run;
    logic [3:0] idle;
    logic core_en;
    cfg_st_t cst;
    logic cfg_req;
    logic cfg_wr;
    logic [5:0] cfg_reg;
    logic [31:0] cfg_wd;
    logic [IDSEL_W-1:0] idsel;
    logic cfg_miss;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;
  logic [NUM_MASTERS-1:0] gnt;
  logic rise;
  logic act;
  logic busy;
  logic cfg_go;
  logic go_wr;
  logic [4:0] dev;
  logic [31:0] status;

  // --------------------------------------------------------------
  // arbitration
  // --------------------------------------------------------------
  // five request/grant pairs
  bus_arbiter #(.N(NUM_MASTERS)) u_arb (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .step(rise),
    .req(s_r.run ? ~s_r.req_s2 : '0),
    .gnt(gnt)
  );

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    rise = 1'b0;
    cfg_go = 1'b0;
    go_wr = 1'b0;
    dev = s_r.cfg_addr[CFG_DEV_LSB +: 5];
    busy = (s_r.cst != CFG_IDLE);
    s_nxt.rdata = '0;
    // two-flop synchronisers for everything the board drives except cfg_rd
    s_nxt.strap_s1 = lnk.strap;
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.req_s1 = lnk.req_n;
    s_nxt.req_s2 = s_r.req_s1;
    s_nxt.crun_s1 = lnk.clkrun_n;
    s_nxt.crun_s2 = s_r.crun_s1;
    s_nxt.ack_s1 = lnk.cfg_ack;
    s_nxt.ack_s2 = s_r.ack_s1;

    // memory address lines read as straps
    // caught once after reset, then frozen
    if (!s_r.strap_ok) begin
      s_nxt.cap = s_r.cap + 2'h1;
      // one extra edge: board straps only leave their reset levels after release
      if (s_r.cap == 2'h3) begin
        s_nxt.strap = s_r.strap_s2;
        s_nxt.strap_ok = 1'b1;
      end
    end

    // clkrun low, a request or own cycle keeps clock
    act = !s_r.crun_s2 || (s_r.req_s2 != '1) || busy;
    if (s_r.run) begin
      if (s_r.div == 3'(PCI_HALF_CYC - 1)) begin
        s_nxt.div = '0;
        s_nxt.pclk = !s_r.pclk;
        rise = !s_r.pclk;
        // stop only on a falling edge so the clock parks low
        if (s_r.pclk) begin
          if (act) begin
            s_nxt.idle = '0;
          end else if (s_r.idle == 4'(RUN_IDLE_PCLKS - 1)) begin
            s_nxt.run = 1'b0;
          end else begin
            s_nxt.idle = s_r.idle + 4'h1;
          end
        end
      end else begin
        s_nxt.div = s_r.div + 3'h1;
      end
    end else if (act) begin
      s_nxt.run = 1'b1;
      s_nxt.idle = '0;
      s_nxt.div = '0;
    end

    // core clock only while processor or bus is busy
    s_nxt.core_en = cpu_active || s_r.run || act;

    // register writes; configuration data is refused while busy
    if (wr) begin
      case (addr)
        REG_CTRL: begin
          s_nxt.ctrl = wdata;
        end
        REG_CFG_ADDR: begin
          s_nxt.cfg_addr = wdata;
        end
        REG_CFG_DATA: begin
          cfg_go = 1'b1;
          go_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // register reads; unmapped words read zero
    status = '0;
    status[ST_STRAP_LSB +: STRAP_W] = s_r.strap;
    status[ST_OK] = s_r.strap_ok;
    status[ST_RUN] = s_r.run;
    status[ST_CORE] = s_r.core_en;
    status[ST_GNT_LSB +: NUM_MASTERS] = gnt;
    status[ST_BUSY] = busy;
    status[ST_MISS] = s_r.cfg_miss;
    // host bus stays at 66 MHz
    status[ST_FAST] = 1'b0;
    if (rd) begin
      case (addr)
        REG_CTRL: s_nxt.rdata = s_r.ctrl;
        REG_STATUS: s_nxt.rdata = status;
        REG_CFG_ADDR: s_nxt.rdata = s_r.cfg_addr;
        REG_CFG_DATA: begin
          s_nxt.rdata = s_r.cfg_rdata;
          cfg_go = 1'b1;
        end
        REG_CFG_RDATA: s_nxt.rdata = s_r.cfg_rdata;
        default: s_nxt.rdata = '0;
      endcase
    end

    // a data-register access with the enable bit of the address word set and bus number zero starts a cycle
    if (cfg_go && !busy && s_r.cfg_addr[CFG_EN_BIT] && s_r.cfg_addr[CFG_BUS_LSB +: 8] == 8'h00) begin
      // device zero answers nothing on the bus
      // graphics slot never gets a select line
      if (dev <= GFX_DEV || dev > MAX_DEV) begin
        s_nxt.cfg_miss = 1'b1;
        s_nxt.cfg_rdata = 32'hFFFF_FFFF;
      end else begin
        s_nxt.cfg_miss = 1'b0;
        s_nxt.idsel = 21'h00_0001 << dev;
        s_nxt.cfg_reg = s_r.cfg_addr[CFG_REG_LSB +: 6];
        s_nxt.cfg_wr = go_wr;
        if (go_wr) begin
          s_nxt.cfg_wd = wdata;
        end
        s_nxt.cfg_req = 1'b1;
        s_nxt.cst = CFG_REQ;
      end
    end

    // four-phase handshake; board holds read data while ack is high
    case (s_r.cst)
      CFG_IDLE: begin
      end
      CFG_REQ: begin
        if (s_r.ack_s2) begin
          if (!s_r.cfg_wr) begin
            s_nxt.cfg_rdata = lnk.cfg_rd;
          end
          s_nxt.cfg_req = 1'b0;
          s_nxt.cst = CFG_DROP;
        end
      end
      CFG_DROP: begin
        if (!s_r.ack_s2) begin
          s_nxt.idsel = '0;
          s_nxt.cst = CFG_IDLE;
        end
      end
      default: begin
        s_nxt.cst = CFG_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.strap <= STRAP_DEFAULT;
      s_r.strap_s1 <= STRAP_DEFAULT;
      s_r.strap_s2 <= STRAP_DEFAULT;
      s_r.req_s1 <= '1;
      s_r.req_s2 <= '1;
      s_r.crun_s1 <= 1'b1;
      s_r.crun_s2 <= 1'b1;
      s_r.ctrl <= CTRL_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign rdata = s_r.rdata;
  assign core_clk_en = s_r.core_en;
  assign lnk.pci_clk = s_r.pclk;
  assign lnk.gnt_n = ~gnt;
  // pull clkrun low ourselves for our own cycles
  assign lnk.dev_crun_o = 1'b0;
  assign lnk.dev_crun_oe = busy;
  assign lnk.cfg_req = s_r.cfg_req;
  assign lnk.cfg_wr = s_r.cfg_wr;
  assign lnk.cfg_reg = s_r.cfg_reg;
  assign lnk.cfg_wd = s_r.cfg_wd;
  assign lnk.idsel = s_r.idsel;
  // none, memory, storage or powered-on suspend
  assign susp_state = susp_t'(s_r.ctrl[CTRL_SUSP_LSB +: 2]);
  // extended mode allows cacheable 1 Mbyte region
  assign mgmt_ram_ext = s_r.ctrl[CTRL_EXT_MGMT];
  // unstrapped queue line gives full depth
  assign ioq_depth = s_r.strap[STRAP_QUEUE] ? 4'(IOQ_DEPTH_MAX) : 4'(IOQ_DEPTH_MIN);
  assign quick_start = s_r.strap[STRAP_QSTART];
  // board pull-up disables the graphics port
  // port enable only; its clock is never tied to clk_sys
  assign gfx_port_en = !s_r.strap[STRAP_GFX_DIS];
  // unstrapped memory map line means standard
  assign std_mem_mode = s_r.strap[STRAP_MEMMAP];
  // buffer strap high picks front side buffers
  assign fsb_buffers = s_r.strap[STRAP_BUFMODE];
  // one enable per bank, parked in memory suspend
  assign bank_cke = (susp_state == SUSP_MEM) ? '0 : s_r.ctrl[CTRL_CKE_LSB +: NUM_BANKS];
endmodule
`default_nettype wire

// [rtl/board_end.sv]
/*
  Board end of the link: drives the strap levels, one request line per
  bus master, the clock-run wire, and answers configuration cycles.
  Assumes everything from the bridge arrives from another domain.
*/
`default_nettype none
module board_end
  import bridge_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  bridge_link_if.brd_mp lnk,
  input wire logic gfx_disable,
  input wire logic [NUM_MASTERS-1:0] master_req,
  output logic [NUM_MASTERS-1:0] master_gnt,
  output logic pci_clk_rise,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_hit,
  output logic south_hit,
  output logic [IDSEL_W-1:0] cfg_sel,
  output logic cfg_write,
  output logic [5:0] cfg_reg,
  output logic [31:0] cfg_wdata
);
  typedef struct packed {
    logic [STRAP_W-1:0] strap;
    logic [NUM_MASTERS-1:0] req_n;
    logic crun_oe;
    logic [NUM_MASTERS-1:0] gnt_s1;
    logic [NUM_MASTERS-1:0] gnt_s2;
    logic pc_s1;
    logic pc_s2;
    logic pc_s3;
    logic prise;
    logic [NUM_MASTERS-1:0] mgnt;
    logic creq_s1;
    logic creq_s2;
    logic ack;
    logic [31:0] rd;
    logic hit;
    logic south;
    logic [IDSEL_W-1:0] sel;
    logic wr;
    logic [5:0] reg_no;
    logic [31:0] wd;
  } brd_state_t;

  brd_state_t s_r;
  brd_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // only the graphics-disable line follows an input; the rest stay at their unstrapped levels
    s_nxt.strap = STRAP_DEFAULT;
    s_nxt.strap[STRAP_GFX_DIS] = gfx_disable;
    s_nxt.req_n = ~master_req;
    // any waiting master pulls clkrun low
    s_nxt.crun_oe = |master_req;
    s_nxt.gnt_s1 = lnk.gnt_n;
    s_nxt.gnt_s2 = s_r.gnt_s1;
    s_nxt.pc_s1 = lnk.pci_clk;
    s_nxt.pc_s2 = s_r.pc_s1;
    s_nxt.pc_s3 = s_r.pc_s2;
    s_nxt.creq_s1 = lnk.cfg_req;
    s_nxt.creq_s2 = s_r.creq_s1;
    // grants are taken on the bridge clock rising edge
    s_nxt.prise = s_r.pc_s2 && !s_r.pc_s3;
    if (s_nxt.prise) begin
      s_nxt.mgnt = ~s_r.gnt_s2;
    end
    s_nxt.hit = 1'b0;
    s_nxt.south = 1'b0;
    if (s_r.creq_s2 && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rd = cfg_rdata;
      s_nxt.hit = 1'b1;
      // lines for AD11 and AD12 are never decoded
      s_nxt.sel = lnk.idsel & ~21'h00_0003;
      s_nxt.south = lnk.idsel[SOUTH_DEV];
      s_nxt.wr = lnk.cfg_wr;
      s_nxt.reg_no = lnk.cfg_reg;
      s_nxt.wd = lnk.cfg_wd;
    end else if (!s_r.creq_s2) begin
      s_nxt.ack = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.strap <= STRAP_DEFAULT;
      s_r.req_n <= '1;
      s_r.gnt_s1 <= '1;
      s_r.gnt_s2 <= '1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign lnk.strap = s_r.strap;
  assign lnk.req_n = s_r.req_n;
  assign lnk.brd_crun_o = 1'b0;
  assign lnk.brd_crun_oe = s_r.crun_oe;
  assign lnk.cfg_ack = s_r.ack;
  assign lnk.cfg_rd = s_r.rd;
  assign master_gnt = s_r.mgnt;
  assign pci_clk_rise = s_r.prise;
  assign cfg_hit = s_r.hit;
  assign south_hit = s_r.south;
  assign cfg_sel = s_r.sel;
  assign cfg_write = s_r.wr;
  assign cfg_reg = s_r.reg_no;
  assign cfg_wdata = s_r.wd;
endmodule
`default_nettype wire

// [tb/bridge_link_sva.sv]
/*
  Checker on the link between bridge end and board end: grants, pci clock
  shape and the configuration handshake.
  Assumes the link signals and clk_sys/rst of the bench are wired in by name.
*/
`default_nettype none
module bridge_link_sva
  import bridge_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_MASTERS-1:0] gnt_n,
  input wire logic pci_clk,
  input wire logic clkrun_n,
  input wire logic cfg_req,
  input wire logic cfg_ack,
  input wire logic [5:0] cfg_reg,
  input wire logic [31:0] cfg_wd,
  input wire logic [IDSEL_W-1:0] idsel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // arbitration and pci clock
  // ------------------------------------------------------------
  chk_gnt_onehot: assert property ($onehot0(~gnt_n))
    else $error("more than one grant active");
  // grants move only on a pci clock rise, so the clock is high then
  chk_gnt_on_tick: assert property (!$stable(gnt_n) |-> pci_clk)
    else $error("grant moved while pci clock low");
  chk_clk_high_four: assert property ($rose(pci_clk) |-> pci_clk [*4] ##1 !pci_clk)
    else $error("pci clock high phase not four cycles");
  chk_clk_run_start: assert property ($fell(clkrun_n) |-> ##[1:24] $rose(pci_clk))
    else $error("pci clock did not run after clkrun request");
  // ------------------------------------------------------------
  // configuration cycles
  // ------------------------------------------------------------
  chk_idsel_self: assert property (cfg_req |-> !idsel[0])
    else $error("own select line driven");
  chk_idsel_gfx: assert property (cfg_req |-> !idsel[1])
    else $error("graphics select line driven");
  chk_idsel_onehot: assert property (cfg_req |-> $onehot(idsel))
    else $error("select lines not one-hot");
  chk_ack_needs_req: assert property ($rose(cfg_ack) |-> cfg_req)
    else $error("acknowledge without request");
  chk_req_drop_ack: assert property ($fell(cfg_req) |-> cfg_ack)
    else $error("request dropped before acknowledge");
  chk_ack_bound: assert property ($rose(cfg_req) |-> ##[1:12] cfg_ack)
    else $error("acknowledge late");
  chk_cfg_hold: assert property (cfg_req && $past(cfg_req) |-> $stable(idsel) && $stable(cfg_wd) && $stable(cfg_reg))
    else $error("request fields changed while pending");
  cov_ack: cover property ($rose(cfg_ack));
  cov_south: cover property (cfg_req && idsel[7]);
  cov_gnt_last: cover property (!gnt_n[4]);
  cov_clk: cover property ($rose(pci_clk));
endmodule
`default_nettype wire

// [tb/bridge_strap_pci_config_tb_top.sv]
/*
  Bench joining the bridge end and the board end through the link, with the
  link checker beside it; drives the register port and the board inputs.
  Assumes the register port answers reads one cycle later.
*/
`default_nettype none
module bridge_strap_pci_config_tb_top
  import bridge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] exp; logic [31:0] msk;} note_t;
  logic clk_sys, rst, ce, wr, rd, cpu_active, gfx_disable, rd_seen;
  logic [7:0] addr;
  logic [31:0] wdata, cfg_rdata, rdata, cfg_wdata;
  logic [NUM_MASTERS-1:0] master_req, master_gnt;
  logic core_clk_en, mgmt_ram_ext, quick_start, gfx_port_en, std_mem_mode, fsb_buffers;
  logic cfg_hit, south_hit, cfg_write, pci_rise;
  susp_t susp_state;
  logic [3:0] ioq_depth;
  logic [NUM_BANKS-1:0] bank_cke, cke;
  logic [IDSEL_W-1:0] cfg_sel;
  logic [5:0] cfg_reg;
  logic [31:0] v;
  note_t q[$];
  note_t cur;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int rises = 0;
  int seed = 32'h20fb;
  int i;
  logic [4:0] devs[6] = '{5'h07, 5'h02, 5'h00, 5'h01, 5'h15, 5'h07};
  logic ens[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic wrs[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  bridge_link_if lnk_if();
  bridge_dev u_bridge_dev(.clk_sys(clk_sys), .rst(rst), .ce(ce), .lnk(lnk_if), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_active(cpu_active), .core_clk_en(core_clk_en), .susp_state(susp_state),
    .mgmt_ram_ext(mgmt_ram_ext), .ioq_depth(ioq_depth), .quick_start(quick_start), .gfx_port_en(gfx_port_en),
    .std_mem_mode(std_mem_mode), .fsb_buffers(fsb_buffers), .bank_cke(bank_cke));
  board_end u_board_end(.clk_sys(clk_sys), .rst(rst), .ce(ce), .lnk(lnk_if), .gfx_disable(gfx_disable),
    .master_req(master_req), .master_gnt(master_gnt), .pci_clk_rise(pci_rise), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
    .south_hit(south_hit), .cfg_sel(cfg_sel), .cfg_write(cfg_write), .cfg_reg(cfg_reg), .cfg_wdata(cfg_wdata));
  bridge_link_sva u_bridge_link_sva(.clk_sys(clk_sys), .rst(rst), .gnt_n(lnk_if.gnt_n), .pci_clk(lnk_if.pci_clk),
    .clkrun_n(lnk_if.clkrun_n), .cfg_req(lnk_if.cfg_req), .cfg_ack(lnk_if.cfg_ack), .cfg_reg(lnk_if.cfg_reg),
    .cfg_wd(lnk_if.cfg_wd), .idsel(lnk_if.idsel));

  // ------------------------------------------------------------
  // clock, report and register port tasks
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the leading edge wait keeps a strobe from being set twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    q.push_back('{e & m, m});
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  task automatic do_reset(input logic gd);
    @(posedge clk_sys);
    rst <= 1'b1;
    gfx_disable <= gd;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // one configuration access, then its outcome on the board side
  task automatic cfg_cycle(input logic en, input logic [4:0] dev, input logic is_wr);
    logic [5:0] rg;
    logic [31:0] d;
    logic hit;
    logic exp_hit;
    int k;
    rg = 6'($random(seed));
    d = $random(seed);
    hit = 1'b0;
    exp_hit = en && dev > GFX_DEV && dev <= MAX_DEV;
    cfg_rdata <= d;
    wr_reg(REG_CFG_ADDR, {en, 7'h00, 8'h00, dev, 3'h0, rg, 2'h0});
    if (is_wr) wr_reg(REG_CFG_DATA, d);
    else rd_reg(REG_CFG_DATA, 32'h0, 32'h0);
    for (k = 0; k < 60 && !hit; k++) begin
      @(posedge clk_sys);
      hit = (cfg_hit === 1'b1);
    end
    check("cfg_hit", 32'(hit), 32'(exp_hit));
    if (hit) begin
      check("cfg_sel", 32'(cfg_sel), 32'(21'h1 << dev));
      check("south_hit", 32'(south_hit), 32'(dev == SOUTH_DEV));
      check("cfg_write", 32'(cfg_write), 32'(is_wr));
      check("cfg_reg", 32'(cfg_reg), 32'(rg));
      if (is_wr) check("cfg_wdata", cfg_wdata, d);
    end
    for (k = 0; k < 60 && (lnk_if.cfg_req || lnk_if.cfg_ack); k++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    if (exp_hit && !is_wr) rd_reg(REG_CFG_RDATA, d, 32'hFFFF_FFFF);
    if (en && !exp_hit) rd_reg(REG_CFG_RDATA, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen && q.size() > 0) begin
      cur = q.pop_front();
      check("rdata", rdata & cur.msk, cur.exp);
    end
    rd_seen <= rd;
  end

  // hang guard, well above the fewer than a thousand cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (pci_rise === 1'b1) rises <= rises + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    rd_seen = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    cpu_active = 1'b0;
    gfx_disable = 1'b0;
    master_req = 5'h00;
    cfg_rdata = 32'h0;
    do_reset(1'b0);
    check("ioq_depth", 32'(ioq_depth), 32'(IOQ_DEPTH_MAX));
    check("quick_start", 32'(quick_start), 32'h1);
    check("gfx_port_en", 32'(gfx_port_en), 32'h1);
    check("std_mem_mode", 32'(std_mem_mode), 32'h1);
    check("fsb_buffers", 32'(fsb_buffers), 32'h1);
    rd_reg(REG_STATUS, 32'h0000_0077, 32'h0001_007F);
    // a late strap change must not reach the captured set
    gfx_disable <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("gfx_port_en", 32'(gfx_port_en), 32'h1);
    rd_reg(REG_STATUS, 32'h0000_0077, 32'h0000_007F);
    do_reset(1'b1);
    check("gfx_port_en", 32'(gfx_port_en), 32'h0);
    rd_reg(REG_STATUS, 32'h0000_007F, 32'h0000_007F);
    do_reset(1'b0);
    for (i = 0; i < 4; i++) begin
      cke = 6'($random(seed));
      v = (32'(cke) << CTRL_CKE_LSB) | 32'(i) | (32'(i & 1) << CTRL_EXT_MGMT);
      wr_reg(REG_CTRL, v);
      @(posedge clk_sys);
      check("susp_state", 32'(susp_state), 32'(i));
      check("mgmt_ram_ext", 32'(mgmt_ram_ext), 32'(i & 1));
      check("bank_cke", 32'(bank_cke), (i == 1) ? 32'h0 : 32'(cke));
      rd_reg(REG_CTRL, v, 32'h0000_3F07);
    end
    rd_reg(8'hFC, 32'h0, 32'hFFFF_FFFF);
    for (i = 0; i < 6; i++) cfg_cycle(ens[i], devs[i], wrs[i]);
    for (i = 0; i < NUM_MASTERS; i++) begin
      master_req <= 5'(1 << i);
      for (int k = 0; k < 200 && master_gnt[i] !== 1'b1; k++) @(posedge clk_sys);
      check("master_gnt", 32'(master_gnt), 32'(1 << i));
      master_req <= 5'h00;
      repeat (20) @(posedge clk_sys);
    end
    master_req <= 5'h05;
    for (int k = 0; k < 200 && (master_gnt & 5'h05) == 5'h00; k++) @(posedge clk_sys);
    check("master_gnt", 32'(master_gnt), 32'h1);
    master_req <= 5'h04;
    for (int k = 0; k < 200 && master_gnt[2] !== 1'b1; k++) @(posedge clk_sys);
    check("master_gnt", 32'(master_gnt), 32'h4);
    check("pci_clk_rise", 32'(rises > 0), 32'h1);
    master_req <= 5'h00;
    repeat (120) @(posedge clk_sys);
    check("pci_clk", 32'(lnk_if.pci_clk), 32'h0);
    check("pci_clk_rise", 32'(pci_rise), 32'h0);
    check("core_clk_en", 32'(core_clk_en), 32'h0);
    rd_reg(REG_STATUS, 32'h0, 32'h0000_0180);
    cpu_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("core_clk_en", 32'(core_clk_en), 32'h1);
    cpu_active <= 1'b0;
    repeat (4) @(posedge clk_sys);
    summarize();
  end
endmodule
`default_nettype wire
